//--- pgr_engine.sv
// Page group response engine: command queue descriptors to response messages
// Overview of operation
// - Each group response descriptor yields message when queue width is 256-bit
// - Type decoded from high and low ranges
// - 128-bit queue width gives invalid descriptor for group responses only
// - Requester ID selects bus, device, function
// - Address-space ID present flag forwarded
// - Address-space ID value sent when present
// - Response codes success, invalid, failure, reserved
// - Private-data flag set includes private data
// - Private data ignored when flag clear
// - Responses and invalidations leave in order
// - Group index nine bits, 0 to 511
module pgr_engine
	import pgr_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic queue_width_select,
	input wire logic desc_valid,
	input wire logic [PGR_DESC_W-1:0] desc_data,
	output logic desc_ready,
	output logic invalid_desc_err,
	output logic unsupported_desc,
	output logic msg_valid,
	input wire logic msg_ready,
	output logic msg_is_inv,
	output logic [PGR_RID_W-1:0] msg_rid,
	output logic msg_pasid_present,
	output logic [PGR_PASID_W-1:0] msg_pasid,
	output logic [PGR_PRGI_W-1:0] msg_prgi,
	output logic [PGR_RESP_W-1:0] msg_resp_code,
	output logic msg_pdp,
	output logic [PGR_PRIV_W-1:0] msg_priv_data,
	output logic [PGR_INV_W-1:0] msg_inv_payload
);
	// ==========================================================
	// Decoder
	pgr_dec_if dif ();
	assign dif.desc = desc_data;
	assign dif.queue_width_select = queue_width_select;
	pgr_desc_decode u_dec (
		.dif(dif)
	);

	pgr_state_t state_reg;
	logic take;
	assign take = desc_valid && desc_ready;

	// ==========================================================
	// Sequencer: one message in flight keeps order
	// single holding stage, submission order
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= PGR_ST_IDLE;
			desc_ready <= 1'b1;
			msg_valid <= 1'b0;
		end else begin
			unique case (state_reg)
				PGR_ST_IDLE: begin
					if (take && !dif.width_err && dif.cls != PGR_CLS_OTHER) begin
						state_reg <= PGR_ST_SEND;
						desc_ready <= 1'b0;
						msg_valid <= 1'b1;
					end
				end
				PGR_ST_SEND: begin
					if (msg_ready) begin
						state_reg <= PGR_ST_IDLE;
						desc_ready <= 1'b1;
						msg_valid <= 1'b0;
					end
				end
				default: begin
					state_reg <= PGR_ST_IDLE;
					desc_ready <= 1'b1;
					msg_valid <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// Error pulses
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			invalid_desc_err <= 1'b0;
			unsupported_desc <= 1'b0;
		end else begin
			invalid_desc_err <= take && dif.width_err;
			unsupported_desc <= take && (dif.cls == PGR_CLS_OTHER);
		end
	end

	// ==========================================================
	// Message fields
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			msg_is_inv <= 1'b0;
			msg_rid <= '0;
			msg_pasid_present <= 1'b0;
			msg_pasid <= '0;
			msg_prgi <= '0;
			msg_resp_code <= PGR_RC_SUCCESS;
			msg_pdp <= 1'b0;
			msg_priv_data <= '0;
			msg_inv_payload <= '0;
		end else if (take && !dif.width_err && dif.cls != PGR_CLS_OTHER) begin
			msg_is_inv <= (dif.cls == PGR_CLS_INV);
			msg_rid <= dif.rid;
			msg_pasid_present <= dif.pasid_present;
			msg_pasid <= dif.pasid_present ? dif.pasid : '0;
			msg_prgi <= dif.prgi;
			msg_resp_code <= dif.resp_code;
			msg_pdp <= dif.private_data_flag;
			msg_priv_data <= dif.private_data_flag ? dif.priv_data : '0;
			msg_inv_payload <= desc_data[PGR_INV_W-1:0];
		end
	end

	// ==========================================================
	// Assertions
	logic acc;
	assign acc = take && !dif.width_err && dif.cls != PGR_CLS_OTHER;

	// accepted response raises message next cycle
	msg_follows_a: assert property (@(posedge core_clk) disable iff (!nrst)
		take && dif.cls == PGR_CLS_GRP && !dif.width_err |=> msg_valid && !msg_is_inv)
		else $error("group response produced no message");
	type_decode_a: assert property (@(posedge core_clk) disable iff (!nrst)
		dif.cls == PGR_CLS_GRP |-> desc_data[11:9] == 3'h0 && desc_data[3:0] == 4'h9)
		else $error("type decode wrong");
	width_err_a: assert property (@(posedge core_clk) disable iff (!nrst)
		take && dif.cls == PGR_CLS_GRP && queue_width_select == PGR_WIDTH_128
		|=> invalid_desc_err && !msg_valid)
		else $error("missing invalid descriptor error");
	rid_copy_a: assert property (@(posedge core_clk) disable iff (!nrst)
		acc |=> msg_rid == $past(desc_data[PGR_RID_MSB:PGR_RID_LSB]))
		else $error("requester id changed");
	// absent address-space ID sent as zero
	pasid_gate_a: assert property (@(posedge core_clk) disable iff (!nrst)
		msg_valid && !msg_pasid_present |-> msg_pasid == '0)
		else $error("pasid leaked without flag");
	priv_gate_a: assert property (@(posedge core_clk) disable iff (!nrst)
		msg_valid && !msg_pdp |-> msg_priv_data == '0)
		else $error("private data leaked");
	priv_copy_a: assert property (@(posedge core_clk) disable iff (!nrst)
		acc && dif.private_data_flag |=> msg_pdp && msg_priv_data == $past(dif.priv_data))
		else $error("private data lost");
	msg_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
		msg_valid && !msg_ready |=> msg_valid && $stable(msg_rid) && $stable(msg_prgi)
		&& !desc_ready)
		else $error("message changed before taken");
	resp_copy_a: assert property (@(posedge core_clk) disable iff (!nrst)
		acc |=> msg_resp_code == $past(dif.resp_code) && msg_prgi == $past(dif.prgi))
		else $error("response code or group index changed");

	unsup_pulse_a: assert property (@(posedge core_clk) disable iff (!nrst)
		take && dif.cls == PGR_CLS_OTHER |=> unsupported_desc && !msg_valid && desc_ready)
		else $error("unsupported descriptor not dropped");
	err_drop_a: assert property (@(posedge core_clk) disable iff (!nrst)
		take && dif.width_err |=> !msg_valid && !unsupported_desc && desc_ready)
		else $error("erroring descriptor produced a message");
	pasid_flag_a: assert property (@(posedge core_clk) disable iff (!nrst)
		acc |=> msg_pasid_present == $past(desc_data[PGR_PASID_PRES_BIT]))
		else $error("pasid present flag changed");
	pasid_copy_a: assert property (@(posedge core_clk) disable iff (!nrst)
		acc && desc_data[PGR_PASID_PRES_BIT]
		|=> msg_pasid == $past(desc_data[PGR_PASID_MSB:PGR_PASID_LSB]))
		else $error("pasid value changed");
	busy_refuse_a: assert property (@(posedge core_clk) disable iff (!nrst)
		msg_valid |-> !desc_ready)
		else $error("descriptor taken while message pending");
	msg_release_a: assert property (@(posedge core_clk) disable iff (!nrst)
		msg_valid && msg_ready |=> !msg_valid && desc_ready)
		else $error("engine not released after message taken");
	inv_kind_a: assert property (@(posedge core_clk) disable iff (!nrst)
		take && dif.cls == PGR_CLS_INV |=> msg_valid && msg_is_inv)
		else $error("invalidation produced no message");
	inv_payload_a: assert property (@(posedge core_clk) disable iff (!nrst)
		acc |=> msg_inv_payload == $past(desc_data[PGR_INV_W-1:0]))
		else $error("payload changed");

	grp_sent_c: cover property (@(posedge core_clk) disable iff (!nrst)
		acc && dif.cls == PGR_CLS_GRP ##1 msg_valid ##[0:3] msg_ready);
	inv_sent_c: cover property (@(posedge core_clk) disable iff (!nrst)
		acc && dif.cls == PGR_CLS_INV);
	width_err_c: cover property (@(posedge core_clk) disable iff (!nrst) invalid_desc_err);
	stall_c: cover property (@(posedge core_clk) disable iff (!nrst)
		(msg_valid && !msg_ready) [*3]);
endmodule

//--- pgr_pkg.sv
// Constants and types for the page group response engine
package pgr_pkg;
	// ==========================================================
	// Descriptor layout
	localparam int PGR_DESC_W = 256;
	localparam int PGR_TYPE_LO_MSB = 3;
	localparam int PGR_TYPE_LO_LSB = 0;
	localparam int PGR_TYPE_HI_MSB = 11;
	localparam int PGR_TYPE_HI_LSB = 9;
	localparam int PGR_PASID_PRES_BIT = 4;
	localparam int PGR_PDP_BIT = 5;
	localparam int PGR_RESP_MSB = 15;
	localparam int PGR_RESP_LSB = 12;
	localparam int PGR_RID_MSB = 31;
	localparam int PGR_RID_LSB = 16;
	localparam int PGR_PASID_MSB = 51;
	localparam int PGR_PASID_LSB = 32;
	localparam int PGR_PRGI_MSB = 72;
	localparam int PGR_PRGI_LSB = 64;
	localparam int PGR_PRIV_MSB = 255;
	localparam int PGR_PRIV_LSB = 128;
	localparam int PGR_INV_W = 128;
	// ==========================================================
	// Field widths
	localparam int PGR_TYPE_W = 7;
	localparam int PGR_RID_W = 16;
	localparam int PGR_BUS_W = 8;
	localparam int PGR_PASID_W = 20;
	localparam int PGR_PRGI_W = 9;
	localparam int PGR_RESP_W = 4;
	localparam int PGR_PRIV_W = 128;
	// ==========================================================
	// Type codes, high part then low part
	localparam logic [6:0] PGR_TYPE_GRP_RESP = 7'h09;
	localparam logic [6:0] PGR_TYPE_DEV_INV = 7'h03;
	localparam logic [6:0] PGR_TYPE_PDEV_INV = 7'h08;
	// Queue width select value for 128-bit descriptors
	localparam logic PGR_WIDTH_128 = 1'b0;
	// ==========================================================
	// Response codes
	localparam logic [3:0] PGR_RC_SUCCESS = 4'h0;
	localparam logic [3:0] PGR_RC_INVALID = 4'h1;
	localparam logic [3:0] PGR_RC_FAILURE = 4'hF;
	// ==========================================================
	typedef enum logic [2:0] {
		PGR_CLS_GRP = 3'b001,
		PGR_CLS_INV = 3'b010,
		PGR_CLS_OTHER = 3'b100
	} pgr_cls_t;
	typedef enum logic [1:0] {
		PGR_ST_IDLE = 2'b01,
		PGR_ST_SEND = 2'b10
	} pgr_state_t;
endpackage

//--- pgr_dec_if.sv
// Carrier between descriptor decoder and engine
interface pgr_dec_if;
	import pgr_pkg::*;
	logic [PGR_DESC_W-1:0] desc;
	logic queue_width_select;
	pgr_cls_t cls;
	logic width_err;
	logic [PGR_RID_W-1:0] rid;
	logic pasid_present;
	logic [PGR_PASID_W-1:0] pasid;
	logic [PGR_PRGI_W-1:0] prgi;
	logic [PGR_RESP_W-1:0] resp_code;
	logic private_data_flag;
	logic [PGR_PRIV_W-1:0] priv_data;
	modport dec (input desc, input queue_width_select, output cls, output width_err,
		output rid, output pasid_present, output pasid, output prgi, output resp_code,
		output private_data_flag, output priv_data);
	modport use_side (output desc, output queue_width_select, input cls, input width_err,
		input rid, input pasid_present, input pasid, input prgi, input resp_code,
		input private_data_flag, input priv_data);
endinterface

//--- pgr_desc_decode.sv
// Combinational descriptor decoder
module pgr_desc_decode
	import pgr_pkg::*;
(
	pgr_dec_if.dec dif
);
	logic [PGR_TYPE_W-1:0] dtype;

	assign dtype = {dif.desc[PGR_TYPE_HI_MSB:PGR_TYPE_HI_LSB],
		dif.desc[PGR_TYPE_LO_MSB:PGR_TYPE_LO_LSB]};

	always_comb begin
		unique case (dtype)
			PGR_TYPE_GRP_RESP: dif.cls = PGR_CLS_GRP;
			PGR_TYPE_DEV_INV, PGR_TYPE_PDEV_INV: dif.cls = PGR_CLS_INV;
			default: dif.cls = PGR_CLS_OTHER;
		endcase
	end

	assign dif.width_err = (dtype == PGR_TYPE_GRP_RESP) &&
		(dif.queue_width_select == PGR_WIDTH_128);

	assign dif.rid = dif.desc[PGR_RID_MSB:PGR_RID_LSB];
	assign dif.pasid_present = dif.desc[PGR_PASID_PRES_BIT];
	assign dif.pasid = dif.desc[PGR_PASID_MSB:PGR_PASID_LSB];
	assign dif.prgi = dif.desc[PGR_PRGI_MSB:PGR_PRGI_LSB];
	assign dif.resp_code = dif.desc[PGR_RESP_MSB:PGR_RESP_LSB];
	assign dif.private_data_flag = dif.desc[PGR_PDP_BIT];
	assign dif.priv_data = dif.desc[PGR_PRIV_MSB:PGR_PRIV_LSB];
endmodule

//--- pgr_endpoint_model.sv
// Endpoint-side model that takes response messages
module pgr_endpoint_model
	import pgr_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic slow,
	input wire logic msg_valid,
	output logic msg_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Ready handshake
	// takes in order
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			msg_ready <= 1'b0;
		end else begin
			msg_ready <= slow ? 1'($urandom % 3 == 0) : 1'b1;
		end
	end
endmodule

//--- pgr_engine_tb.sv
// Self-checking bench for the page group response engine
module pgr_engine_tb
	import pgr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [307:0] INV_MASK = {1'b1, 179'h0, {128{1'b1}}};
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic queue_width_select = 1'b1;
	logic desc_valid = 1'b0;
	logic [PGR_DESC_W-1:0] desc_data = '0;
	logic slow = 1'b0;
	logic desc_ready, invalid_desc_err, unsupported_desc, msg_valid, msg_ready, msg_is_inv;
	logic [PGR_RID_W-1:0] msg_rid;
	logic msg_pasid_present, msg_pdp;
	logic [PGR_PASID_W-1:0] msg_pasid;
	logic [PGR_PRGI_W-1:0] msg_prgi;
	logic [PGR_RESP_W-1:0] msg_resp_code;
	logic [PGR_PRIV_W-1:0] msg_priv_data;
	logic [PGR_INV_W-1:0] msg_inv_payload;
	logic [307:0] exp_q[$];
	logic inv_q[$];
	logic [307:0] act, mon_e;
	logic mon_i, w;
	logic [6:0] ty;
	logic rep_last_in_group_flag, rep_pdp;
	logic [3:0] rcode;
	logic [6:0] tys[5] = '{PGR_TYPE_GRP_RESP, PGR_TYPE_DEV_INV, PGR_TYPE_PDEV_INV, 7'h19, 7'h05};
	int failures = 0;
	int cmp_count = 0;
	assign act = {msg_is_inv, msg_rid, msg_pasid_present, msg_pasid, msg_prgi, msg_resp_code,
		msg_pdp, msg_priv_data, msg_inv_payload};
	always #4 core_clk = ~core_clk;
	pgr_engine i_pgr_engine (.core_clk(core_clk), .nrst(nrst),
		.queue_width_select(queue_width_select), .desc_valid(desc_valid),
		.desc_data(desc_data), .desc_ready(desc_ready), .invalid_desc_err(invalid_desc_err),
		.unsupported_desc(unsupported_desc), .msg_valid(msg_valid), .msg_ready(msg_ready),
		.msg_is_inv(msg_is_inv), .msg_rid(msg_rid), .msg_pasid_present(msg_pasid_present),
		.msg_pasid(msg_pasid), .msg_prgi(msg_prgi), .msg_resp_code(msg_resp_code),
		.msg_pdp(msg_pdp), .msg_priv_data(msg_priv_data), .msg_inv_payload(msg_inv_payload));
	pgr_endpoint_model i_pgr_endpoint_model (.core_clk(core_clk), .nrst(nrst), .slow(slow),
		.msg_valid(msg_valid), .msg_ready(msg_ready));
	// ==========================================================
	// Compare and report
	task automatic cmp(logic [307:0] e, logic [307:0] a);
		cmp_count++;
		if (a !== e) begin
			failures++;
			$display("wrong value at %0t: exp %0h got %0h", $time, e, a);
		end
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Absent address-space ID and private data read as zero
	function automatic logic [307:0] expect_msg(logic [255:0] d, logic inv);
		logic pp;
		logic pd;
		pp = d[PGR_PASID_PRES_BIT];
		pd = d[PGR_PDP_BIT];
		return {inv, d[PGR_RID_MSB:PGR_RID_LSB], pp, pp ? d[PGR_PASID_MSB:PGR_PASID_LSB] : 20'h0,
			d[PGR_PRGI_MSB:PGR_PRGI_LSB], d[PGR_RESP_MSB:PGR_RESP_LSB], pd,
			pd ? d[PGR_PRIV_MSB:PGR_PRIV_LSB] : 128'h0, d[127:0]};
	endfunction
	function automatic logic [3:0] host_code(logic [2:0] outcome);
		if (outcome < 3'h5) return PGR_RC_SUCCESS;
		if (outcome < 3'h7) return PGR_RC_INVALID;
		return PGR_RC_FAILURE;
	endfunction
	// ==========================================================
	// Descriptor driver, entered at a falling edge
	task automatic send(logic [6:0] t, logic wd, logic [3:0] rc, logic [8:0] gi, logic pd);
		logic [255:0] d;
		int n;
		logic grp;
		logic inv;
		for (int k = 0; k < 8; k++) d[k*32 +: 32] = $urandom;
		d[PGR_TYPE_HI_MSB:PGR_TYPE_HI_LSB] = t[6:4];
		d[PGR_TYPE_LO_MSB:PGR_TYPE_LO_LSB] = t[3:0];
		d[PGR_RESP_MSB:PGR_RESP_LSB] = rc;
		d[PGR_PRGI_MSB:PGR_PRGI_LSB] = gi;
		d[PGR_PDP_BIT] = pd;
		grp = (t == PGR_TYPE_GRP_RESP);
		inv = (t == PGR_TYPE_DEV_INV) || (t == PGR_TYPE_PDEV_INV);
		desc_data = d;
		desc_valid = 1'b1;
		queue_width_select = wd;
		n = 0;
		while (desc_ready !== 1'b1 && n < 50) begin
			@(negedge core_clk);
			n++;
		end
		if (n == 50) cmp(308'h1, 308'(desc_ready));
		if ((grp && wd) || inv) begin
			exp_q.push_back(expect_msg(d, inv));
			inv_q.push_back(inv);
		end
		@(negedge core_clk);
		cmp(308'({grp && !wd, !grp && !inv}), 308'({invalid_desc_err, unsupported_desc}));
	endtask
	// ==========================================================
	// Message monitor, sampled between edges
	always @(negedge core_clk) begin
		if (nrst && msg_valid === 1'b1 && msg_ready === 1'b1) begin
			if (exp_q.size() == 0) begin
				failures++;
				$display("wrong value at %0t: exp %0h got %0h", $time, 308'h0, act);
			end else begin
				mon_e = exp_q.pop_front();
				mon_i = inv_q.pop_front();
				cmp(mon_i ? mon_e & INV_MASK : mon_e, mon_i ? act & INV_MASK : act);
			end
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(52929));
		repeat (12) @(negedge core_clk);
		nrst = 1'b1;
		cmp(308'h2, 308'({desc_ready, msg_valid}));
		for (int i = 0; i < 240; i++) begin
			slow = i[5];
			ty = i < 16 ? PGR_TYPE_GRP_RESP : tys[$urandom % 5];
			w = i < 16 ? 1'b1 : 1'($urandom % 4 != 0);
			// Fault report behind the response
			rep_last_in_group_flag = 1'($urandom);
			rep_pdp = 1'($urandom);
			rcode = i < 16 ? i[3:0] : host_code(3'($urandom));
			if (i >= 16 && ty == PGR_TYPE_GRP_RESP && !rep_last_in_group_flag && !rep_pdp) continue;
			send(ty, w, rcode, i == 0 ? 9'h1FF : 9'($urandom), rep_pdp);
		end
		desc_valid = 1'b0;
		for (int n = 0; n < 100 && exp_q.size() != 0; n++) @(negedge core_clk);
		cmp(308'h0, 308'(exp_q.size()));
		final_report();
	end
	initial begin
		#100000;
		failures++;
		final_report();
	end
endmodule
